// ---- rtl/dsnr_pkg.sv ----
// constants for the dip, swell, no-load and source-select register bank
package dsnr_pkg;
	// printed offsets are word indices; byte address is four times the index
	localparam logic [11:0] DSNR_IDX_DIP_THR = 12'h410;
	localparam logic [11:0] DSNR_IDX_DIP_CAP_A = 12'h411;
	localparam logic [11:0] DSNR_IDX_DIP_CAP_B = 12'h412;
	localparam logic [11:0] DSNR_IDX_DIP_CAP_C = 12'h413;
	localparam logic [11:0] DSNR_IDX_SWL_THR = 12'h414;
	localparam logic [11:0] DSNR_IDX_SWL_CAP_A = 12'h415;
	localparam logic [11:0] DSNR_IDX_SWL_CAP_B = 12'h416;
	localparam logic [11:0] DSNR_IDX_SWL_CAP_C = 12'h417;
	localparam logic [11:0] DSNR_IDX_NOLOAD = 12'h41f;
	localparam logic [11:0] DSNR_IDX_SRC_SEL = 12'h424;
	localparam logic [11:0] DSNR_IDX_IRQ_STAT = 12'h430;
	localparam logic [11:0] DSNR_IDX_IRQ_MASK = 12'h431;
	localparam int DSNR_RMS_W = 24;
	localparam int DSNR_NL_W = 18;
	localparam int DSNR_SEL_W = 21;
	localparam int DSNR_IRQ_W = 6;
	localparam logic [23:0] DSNR_DIP_THR_RST = 24'h000000;
	localparam logic [23:0] DSNR_DIP_CAP_RST = 24'h7fffff;
	localparam logic [23:0] DSNR_SWL_THR_RST = 24'hffffff;
	localparam logic [23:0] DSNR_SWL_CAP_RST = 24'h000000;
	localparam logic [20:0] DSNR_SEL_RST = 21'h1fffff;
	localparam logic [2:0] DSNR_SRC_IA = 3'h0;
	localparam logic [2:0] DSNR_SRC_IB = 3'h1;
	localparam logic [2:0] DSNR_SRC_IC = 3'h2;
	localparam logic [2:0] DSNR_SRC_IN = 3'h3;
	localparam logic [2:0] DSNR_SRC_VA = 3'h4;
	localparam logic [2:0] DSNR_SRC_VB = 3'h5;
	localparam logic [2:0] DSNR_SRC_VC = 3'h6;
	localparam logic [2:0] DSNR_SRC_OWN = 3'h7;
	// channel order in the select word, low field first
	localparam int DSNR_CH_IA = 0;
	localparam int DSNR_CH_IB = 1;
	localparam int DSNR_CH_IC = 2;
	localparam int DSNR_CH_IN = 3;
	localparam int DSNR_CH_VA = 4;
	localparam int DSNR_CH_VB = 5;
	localparam int DSNR_CH_VC = 6;
	localparam int DSNR_NCH = 7;
endpackage

// ---- rtl/dsnr_regs.sv ----
// apb register bank for dip and swell capture, no-load status and channel_source_select
`timescale 1ns/1ps
`default_nettype none
module dsnr_regs
	import dsnr_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [13:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic half_rms_valid_i,
	input wire logic [23:0] half_rms_phase_a_i,
	input wire logic [23:0] half_rms_phase_b_i,
	input wire logic [23:0] half_rms_phase_c_i,
	input wire logic [17:0] no_load_i,
	input wire logic [SAMPLE_W-1:0] current_phase_a_i,
	input wire logic [SAMPLE_W-1:0] current_phase_b_i,
	input wire logic [SAMPLE_W-1:0] current_phase_c_i,
	input wire logic [SAMPLE_W-1:0] current_neutral_i,
	input wire logic [SAMPLE_W-1:0] voltage_phase_a_i,
	input wire logic [SAMPLE_W-1:0] voltage_phase_b_i,
	input wire logic [SAMPLE_W-1:0] voltage_phase_c_i,
	output logic [DSNR_NCH*SAMPLE_W-1:0] channel_data_o,
	output logic irq_o
);
	// one sample must fit a bus word
	if (SAMPLE_W < 1 || SAMPLE_W > 32) begin : g_bad_width
		$error("SAMPLE_W out of range");
	end

	logic [23:0] dip_threshold_value;
	logic [23:0] swell_threshold_value;
	logic [23:0] dip_rms_phase_a;
	logic [23:0] dip_rms_phase_b;
	logic [23:0] dip_rms_phase_c;
	logic [23:0] swell_rms_phase_a;
	logic [23:0] swell_rms_phase_b;
	logic [23:0] swell_rms_phase_c;
	logic [17:0] no_load;
	logic [20:0] source_select;
	logic [5:0] irq_status;
	logic [5:0] irq_mask;
	logic [17:0] no_load_s1;
	logic [17:0] no_load_s2;

	// apb decode; zero-wait slave, answers in the access cycle
	wire logic access = psel_i & penable_i;
	wire logic wr_en = access & pwrite_i;
	wire logic [11:0] word_idx = paddr_i[13:2];
	wire logic hit_dip_thr = word_idx == DSNR_IDX_DIP_THR;
	wire logic hit_swl_thr = word_idx == DSNR_IDX_SWL_THR;
	wire logic hit_sel = word_idx == DSNR_IDX_SRC_SEL;
	wire logic hit_stat = word_idx == DSNR_IDX_IRQ_STAT;
	wire logic hit_mask = word_idx == DSNR_IDX_IRQ_MASK;
	wire logic hit_ro = (word_idx >= DSNR_IDX_DIP_CAP_A && word_idx <= DSNR_IDX_DIP_CAP_C)
		|| (word_idx >= DSNR_IDX_SWL_CAP_A && word_idx <= DSNR_IDX_SWL_CAP_C)
		|| word_idx == DSNR_IDX_NOLOAD;
	wire logic mapped = hit_dip_thr | hit_swl_thr | hit_sel | hit_stat | hit_mask | hit_ro;
	// writes to read-only words flag an error, misaligned bytes are ignored
	wire logic bad = ~mapped | (pwrite_i & hit_ro);

	// dip and swell detection per phase
	// dip below threshold
	wire logic dip_a = half_rms_valid_i & (half_rms_phase_a_i < dip_threshold_value);
	wire logic dip_b = half_rms_valid_i & (half_rms_phase_b_i < dip_threshold_value);
	wire logic dip_c = half_rms_valid_i & (half_rms_phase_c_i < dip_threshold_value);
	wire logic swl_a = half_rms_valid_i & (half_rms_phase_a_i > swell_threshold_value);
	wire logic swl_b = half_rms_valid_i & (half_rms_phase_b_i > swell_threshold_value);
	wire logic swl_c = half_rms_valid_i & (half_rms_phase_c_i > swell_threshold_value);
	wire logic [5:0] irq_events = {swl_c, swl_b, swl_a, dip_c, dip_b, dip_a};
	wire logic [5:0] stat_clear = (wr_en & hit_stat) ? pwdata_i[5:0] : 6'h00;

	logic [31:0] read_mux;
	always_comb begin
		read_mux = 32'h00000000;
		case (word_idx)
			DSNR_IDX_DIP_THR: read_mux = {8'h00, dip_threshold_value};
			DSNR_IDX_DIP_CAP_A: read_mux = {8'h00, dip_rms_phase_a};
			DSNR_IDX_DIP_CAP_B: read_mux = {8'h00, dip_rms_phase_b};
			DSNR_IDX_DIP_CAP_C: read_mux = {8'h00, dip_rms_phase_c};
			DSNR_IDX_SWL_THR: read_mux = {8'h00, swell_threshold_value};
			DSNR_IDX_SWL_CAP_A: read_mux = {8'h00, swell_rms_phase_a};
			DSNR_IDX_SWL_CAP_B: read_mux = {8'h00, swell_rms_phase_b};
			DSNR_IDX_SWL_CAP_C: read_mux = {8'h00, swell_rms_phase_c};
			DSNR_IDX_NOLOAD: read_mux = {14'h0000, no_load};
			DSNR_IDX_SRC_SEL: read_mux = {11'h000, source_select};
			DSNR_IDX_IRQ_STAT: read_mux = {26'h0000000, irq_status};
			DSNR_IDX_IRQ_MASK: read_mux = {26'h0000000, irq_mask};
			default: read_mux = 32'h00000000;
		endcase
	end

	// pready, pslverr and prdata all launch on the setup edge
	wire logic setup = psel_i & ~penable_i;
	wire logic next_pready = setup;
	wire logic next_pslverr = setup & bad;
	// zero outside reads, so stale data never shows on the bus
	wire logic [31:0] next_prdata = (setup & ~pwrite_i) ? read_mux : 32'h00000000;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
		end else begin
			pready_o <= next_pready;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= next_pslverr;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h00000000;
		end else begin
			prdata_o <= next_prdata;
		end
	end

	// writes take effect on the access edge, pready being high then
	wire logic wr_take = wr_en & pready_o;
	wire logic wr_dip_thr = wr_take & hit_dip_thr;
	wire logic wr_swl_thr = wr_take & hit_swl_thr;
	wire logic wr_sel = wr_take & hit_sel;
	wire logic wr_mask = wr_take & hit_mask;
	wire logic [23:0] next_dip_threshold_value = wr_dip_thr ? pwdata_i[23:0] : dip_threshold_value;
	wire logic [23:0] next_swell_threshold_value = wr_swl_thr ? pwdata_i[23:0] : swell_threshold_value;
	wire logic [20:0] next_source_select = wr_sel ? pwdata_i[20:0] : source_select;
	wire logic [5:0] next_irq_mask = wr_mask ? pwdata_i[5:0] : irq_mask;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dip_threshold_value <= DSNR_DIP_THR_RST;
		end else begin
			dip_threshold_value <= next_dip_threshold_value;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			swell_threshold_value <= DSNR_SWL_THR_RST;
		end else begin
			swell_threshold_value <= next_swell_threshold_value;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			source_select <= DSNR_SEL_RST;
		end else begin
			source_select <= next_source_select;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_mask <= 6'h00;
		end else begin
			irq_mask <= next_irq_mask;
		end
	end

	wire logic [23:0] next_dip_rms_phase_a = dip_a ? half_rms_phase_a_i : dip_rms_phase_a;
	wire logic [23:0] next_dip_rms_phase_b = dip_b ? half_rms_phase_b_i : dip_rms_phase_b;
	wire logic [23:0] next_dip_rms_phase_c = dip_c ? half_rms_phase_c_i : dip_rms_phase_c;
	wire logic [23:0] next_swell_rms_phase_a = swl_a ? half_rms_phase_a_i : swell_rms_phase_a;
	wire logic [23:0] next_swell_rms_phase_b = swl_b ? half_rms_phase_b_i : swell_rms_phase_b;
	wire logic [23:0] next_swell_rms_phase_c = swl_c ? half_rms_phase_c_i : swell_rms_phase_c;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dip_rms_phase_a <= DSNR_DIP_CAP_RST;
		end else begin
			dip_rms_phase_a <= next_dip_rms_phase_a;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dip_rms_phase_b <= DSNR_DIP_CAP_RST;
		end else begin
			dip_rms_phase_b <= next_dip_rms_phase_b;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dip_rms_phase_c <= DSNR_DIP_CAP_RST;
		end else begin
			dip_rms_phase_c <= next_dip_rms_phase_c;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			swell_rms_phase_a <= DSNR_SWL_CAP_RST;
		end else begin
			swell_rms_phase_a <= next_swell_rms_phase_a;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			swell_rms_phase_b <= DSNR_SWL_CAP_RST;
		end else begin
			swell_rms_phase_b <= next_swell_rms_phase_b;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			swell_rms_phase_c <= DSNR_SWL_CAP_RST;
		end else begin
			swell_rms_phase_c <= next_swell_rms_phase_c;
		end
	end

	// no-load flags come from the energy datapath, treated as asynchronous
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			no_load_s1 <= 18'h00000;
			no_load_s2 <= 18'h00000;
		end else begin
			no_load_s1 <= no_load_i;
			no_load_s2 <= no_load_s1;
		end
	end

	wire logic pa_total_active_idle = no_load_s2[0];
	wire logic pa_total_reactive_idle = no_load_s2[1];
	wire logic pa_total_apparent_idle = no_load_s2[2];
	wire logic pa_fund_active_idle = no_load_s2[3];
	wire logic pa_fund_reactive_idle = no_load_s2[4];
	wire logic pa_fund_apparent_idle = no_load_s2[5];
	wire logic pb_total_active_idle = no_load_s2[6];
	wire logic pb_total_reactive_idle = no_load_s2[7];
	wire logic pb_total_apparent_idle = no_load_s2[8];
	wire logic pb_fund_active_idle = no_load_s2[9];
	wire logic pb_fund_reactive_idle = no_load_s2[10];
	wire logic pb_fund_apparent_idle = no_load_s2[11];
	// phase c flags, bit 12 taken as phase c
	wire logic pc_total_active_idle = no_load_s2[12];
	wire logic pc_total_reactive_idle = no_load_s2[13];
	wire logic pc_total_apparent_idle = no_load_s2[14];
	wire logic pc_fund_active_idle = no_load_s2[15];
	wire logic pc_fund_reactive_idle = no_load_s2[16];
	wire logic pc_fund_apparent_idle = no_load_s2[17];
	// status follows the flags, never written
	wire logic [17:0] next_no_load = {pc_fund_apparent_idle, pc_fund_reactive_idle, pc_fund_active_idle,
		pc_total_apparent_idle, pc_total_reactive_idle, pc_total_active_idle,
		pb_fund_apparent_idle, pb_fund_reactive_idle, pb_fund_active_idle,
		pb_total_apparent_idle, pb_total_reactive_idle, pb_total_active_idle,
		pa_fund_apparent_idle, pa_fund_reactive_idle, pa_fund_active_idle,
		pa_total_apparent_idle, pa_total_reactive_idle, pa_total_active_idle};

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			no_load <= 18'h00000;
		end else begin
			no_load <= next_no_load;
		end
	end

	// sticky dip and swell events; set wins so no event is lost to a clear
	wire logic [5:0] next_irq_status = (irq_status & ~(wr_take ? stat_clear : 6'h00)) | irq_events;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_status <= 6'h00;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// one cycle behind status, so the pin comes straight from a flop
	wire logic next_irq = |(irq_status & irq_mask);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= next_irq;
		end
	end

	// channel redirect: one mux per channel, shared code table
	wire logic [SAMPLE_W-1:0] adc_in [DSNR_NCH];
	assign adc_in[DSNR_CH_IA] = current_phase_a_i;
	assign adc_in[DSNR_CH_IB] = current_phase_b_i;
	assign adc_in[DSNR_CH_IC] = current_phase_c_i;
	assign adc_in[DSNR_CH_IN] = current_neutral_i;
	assign adc_in[DSNR_CH_VA] = voltage_phase_a_i;
	assign adc_in[DSNR_CH_VB] = voltage_phase_b_i;
	assign adc_in[DSNR_CH_VC] = voltage_phase_c_i;

	// one flop process for the whole bus keeps a single driver
	wire logic [DSNR_NCH*SAMPLE_W-1:0] next_channel_data;

	for (genvar ch = 0; ch < DSNR_NCH; ch++) begin : g_chan
		wire logic [2:0] code = source_select[3*ch +: 3];
		// code 7 keeps own adc, 0..6 pick by index
		wire logic [SAMPLE_W-1:0] picked = (code == DSNR_SRC_OWN) ? adc_in[ch] : adc_in[code];
		assign next_channel_data[ch*SAMPLE_W +: SAMPLE_W] = picked;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			channel_data_o <= '0;
		end else begin
			channel_data_o <= next_channel_data;
		end
	end
endmodule
`default_nettype wire

// ---- tb/dsnr_regs_chk.sv ----
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module dsnr_regs_chk
	import dsnr_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [13:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [17:0] no_load_i,
	input wire logic irq_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [11:0] idx = paddr_i[13:2];
	wire logic rd_done = pready_o && !pwrite_i;
	wire logic in_bank = idx >= DSNR_IDX_DIP_THR && idx <= DSNR_IDX_SWL_CAP_C;
	wire logic ro_word = in_bank && idx != DSNR_IDX_DIP_THR && idx != DSNR_IDX_SWL_THR || idx == DSNR_IDX_NOLOAD;
	wire logic mapped = in_bank || idx == DSNR_IDX_NOLOAD || idx == DSNR_IDX_SRC_SEL || idx == DSNR_IDX_IRQ_STAT
		|| idx == DSNR_IDX_IRQ_MASK;
	logic [17:0] nl_prev;
	logic [3:0] nl_cnt;
	// stable-input age, saturating so long idle runs stay valid
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nl_prev <= '0;
			nl_cnt <= '0;
		end else begin
			nl_prev <= no_load_i;
			nl_cnt <= (no_load_i != nl_prev) ? 4'h0 : (nl_cnt == 4'hf) ? nl_cnt : nl_cnt + 4'h1;
		end
	end
	chk_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	chk_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error outside access");
	chk_bank_upper_zero: assert property (rd_done && in_bank |-> prdata_o[31:24] == 8'h00)
		else $error("upper byte not zero");
	chk_nl_reserved: assert property (rd_done && idx == DSNR_IDX_NOLOAD |-> prdata_o[31:18] == 14'h0)
		else $error("no-load reserved bits set");
	chk_nl_follows: assert property (rd_done && idx == DSNR_IDX_NOLOAD && nl_cnt >= 4'h6 |-> prdata_o[17:0] == no_load_i)
		else $error("no-load bits differ from input");
	chk_sel_reserved: assert property (rd_done && idx == DSNR_IDX_SRC_SEL |-> prdata_o[31:21] == 11'h0)
		else $error("select reserved bits set");
	chk_unmapped_err: assert property (pready_o && !mapped |-> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped access not refused");
	chk_ro_write_err: assert property (pready_o && pwrite_i && ro_word |-> pslverr_o)
		else $error("read-only write not refused");
	cov_nl_read: cover property (rd_done && idx == DSNR_IDX_NOLOAD && nl_cnt >= 4'h6);
	cov_unmapped: cover property (pready_o && !mapped);
	cov_irq: cover property ($rose(irq_o));
endmodule
bind dsnr_regs dsnr_regs_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .no_load_i(no_load_i), .irq_o(irq_o));
`default_nettype wire

// ---- tb/dsnr_regs_tb.sv ----
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module dsnr_regs_tb
	import dsnr_pkg::*;
;
	logic core_clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0, valid = 0, rerr;
	logic [13:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat, s;
	logic pready, pslverr, irq;
	logic [17:0] nl = '0;
	logic [23:0] rms[3] = '{default: 24'h0};
	logic [23:0] smp[7] = '{default: 24'h0};
	logic [DSNR_NCH*24-1:0] chd;
	int fail_count = 0, checked = 0;
	logic [11:0] ridx[10] = '{12'h410, 12'h411, 12'h412, 12'h413, 12'h414, 12'h415, 12'h416, 12'h417, 12'h41f, 12'h424};
	logic [31:0] rrst[10] = '{32'h0, 32'h7fffff, 32'h7fffff, 32'h7fffff, 32'hffffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1fffff};
	dsnr_regs dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.half_rms_valid_i(valid), .half_rms_phase_a_i(rms[0]), .half_rms_phase_b_i(rms[1]), .half_rms_phase_c_i(rms[2]),
		.no_load_i(nl), .current_phase_a_i(smp[0]), .current_phase_b_i(smp[1]), .current_phase_c_i(smp[2]),
		.current_neutral_i(smp[3]), .voltage_phase_a_i(smp[4]), .voltage_phase_b_i(smp[5]), .voltage_phase_c_i(smp[6]),
		.channel_data_o(chd), .irq_o(irq));
	initial begin
		forever #10 core_clk_i = ~core_clk_i;
	end
	task finish_test();
		if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
		@(posedge core_clk_i);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1;
		// a wait ends when pready is seen high; only the watchdog ends one where it never rises
		do begin
			@(posedge core_clk_i);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input logic [11:0] idx, input logic [31:0] exp, input logic eexp);
		apb(0, idx, 0);
		chk(rdat, exp);
		chk({31'h0, rerr}, {31'h0, eexp});
	endtask
	function automatic logic [23:0] route(input logic [20:0] sel, input int k);
		logic [2:0] c;
		c = sel[3*k+:3];
		// own adc on code 7, shared table otherwise
		return (c == 3'h7) ? smp[k] : smp[c];
	endfunction
	task sel_check(input logic [20:0] v);
		apb(1, DSNR_IDX_SRC_SEL, {11'h7ff, v});
		repeat (3) @(posedge core_clk_i);
		for (int k = 0; k < DSNR_NCH; k++) chk({8'h0, chd[24*k+:24]}, {8'h0, route(v, k)});
		rd(DSNR_IDX_SRC_SEL, {11'h0, v}, 0);
	endtask
	initial begin
		#(20 * 20000);
		fail_count++;
		finish_test();
	end
	initial begin
		s = $urandom(56);
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1;
		for (int i = 0; i < 10; i++) rd(ridx[i], rrst[i], 0);
		rd(12'h418, 32'h0, 1);
		apb(1, DSNR_IDX_DIP_CAP_B, 32'h12345);
		chk({31'h0, rerr}, 32'h1);
		rd(DSNR_IDX_DIP_CAP_B, 32'h7fffff, 0);
		apb(1, DSNR_IDX_DIP_THR, 32'hffffffff);
		rd(DSNR_IDX_DIP_THR, 32'hffffff, 0);
		s = $urandom;
		apb(1, DSNR_IDX_SWL_THR, s);
		rd(DSNR_IDX_SWL_THR, {8'h0, s[23:0]}, 0);
		for (int i = 0; i < 3; i++) begin
			nl <= (i == 0) ? 18'h3ffff : (18'h00001 << (i * 7)) | 18'($urandom);
			repeat (8) @(posedge core_clk_i);
			rd(DSNR_IDX_NOLOAD, {14'h0, nl}, 0);
		end
		apb(1, DSNR_IDX_NOLOAD, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		rd(DSNR_IDX_NOLOAD, {14'h0, nl}, 0);
		apb(1, DSNR_IDX_DIP_THR, 32'h100000);
		apb(1, DSNR_IDX_SWL_THR, 32'h600000);
		rms <= '{24'h0fffff, 24'h600000, 24'h600001};
		valid <= 1;
		@(posedge core_clk_i);
		valid <= 0;
		for (int i = 0; i < 3; i++) rd(DSNR_IDX_DIP_CAP_A + i, (i == 0) ? 32'h0fffff : 32'h7fffff, 0);
		for (int i = 0; i < 3; i++) rd(DSNR_IDX_SWL_CAP_A + i, (i == 2) ? 32'h600001 : 32'h0, 0);
		rd(DSNR_IDX_IRQ_STAT, 32'h21, 0);
		chk({31'h0, irq}, 32'h0);
		apb(1, DSNR_IDX_IRQ_MASK, 32'h20);
		repeat (3) @(posedge core_clk_i);
		chk({31'h0, irq}, 32'h1);
		apb(1, DSNR_IDX_IRQ_STAT, 32'h20);
		repeat (3) @(posedge core_clk_i);
		chk({31'h0, irq}, 32'h0);
		rd(DSNR_IDX_IRQ_STAT, 32'h01, 0);
		for (int k = 0; k < DSNR_NCH; k++) smp[k] <= 24'($urandom);
		// every code in the phase c voltage field, others left at own
		for (int c = 0; c < 8; c++) sel_check({c[2:0], 18'h3ffff});
		for (int i = 0; i < 4; i++) sel_check(21'($urandom));
		finish_test();
	end
endmodule
`default_nettype wire
